// *** core/sarc_ctrl.sv ***
/*
 * Successive-approximation converter control: trigger selection,
 * result capture, window compare, status and register port.
 * Assumes the analog core answers each start with one result word
 * on a valid/ready channel, and timer overflows are clk pulses.
 */
`timescale 1ns/10ps
module sarc_ctrl #(
    parameter int RES_W = sarc_pkg::RW
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire sarc_pkg::sarc_bus_req_t bus_req,
    output logic [sarc_pkg::DW-1:0] rdata,
    // Trigger sources
    input wire sarc_pkg::sarc_timers_t timers,
    input wire logic ext_start_pin,
    // Analog core control
    output sarc_pkg::sarc_analog_ctl_t analog_ctl,
    // Analog core result
    input wire logic conv_valid,
    input wire logic [RES_W-1:0] conv_data,
    output logic conv_ready,
    // Interrupt requests
    output logic done_irq,
    output logic win_irq
);

    // ***********************************
    // State
    // ***********************************
    typedef enum {
        ST_IDLE,
        ST_BUSY
    } sarc_fsm_t;

    typedef struct packed {
        sarc_fsm_t fsm;
        logic [sarc_pkg::CTRL_BITS-1:0] ctrl;
        logic [sarc_pkg::CW-1:0] mux;
        logic [RES_W-1:0] win_hi;
        logic [RES_W-1:0] win_lo;
        logic [RES_W-1:0] result;
        logic done_flag;
        logic win_flag;
        logic ext_prev;
        logic start;
        logic done_irq;
        logic win_irq;
        logic [sarc_pkg::DW-1:0] rdata;
    } sarc_ctrl_st_t;

    sarc_ctrl_st_t st_reg;
    sarc_ctrl_st_t st_next;
    logic ext_level;
    logic buf_valid;
    logic [RES_W-1:0] buf_data;
    logic buf_ready;
    logic trig;
    logic enabled;
    logic in_window;
    logic hit;
    logic [sarc_pkg::DW-1:0] rd_mux;
    sarc_pkg::sarc_trig_t trig_sel;

    // ***********************************
    // Submodules
    // ***********************************
    sarc_sync u_ext_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in(ext_start_pin),
        .level_out(ext_level)
    );

    sarc_buf #(
        .W(RES_W)
    ) u_res_buf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(conv_valid),
        .in_data(conv_data),
        .in_ready(conv_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_ready)
    );

    // ***********************************
    // Trigger and compare
    // ***********************************
    always_comb begin
        trig_sel = sarc_pkg::sarc_trig_t'(
            st_reg.ctrl[sarc_pkg::CTRL_TRIG_HI:sarc_pkg::CTRL_TRIG_LO]);
        enabled = st_reg.ctrl[sarc_pkg::CTRL_EN];
        case (trig_sel)
            sarc_pkg::TRIG_SW: begin
                trig = bus_req.wr && (bus_req.addr == sarc_pkg::ADDR_START)
                    && bus_req.wdata[sarc_pkg::START_GO];
            end
            sarc_pkg::TRIG_T0: begin
                trig = timers.t0_ovf;
            end
            sarc_pkg::TRIG_T1: begin
                trig = timers.t1_ovf;
            end
            sarc_pkg::TRIG_T2: begin
                trig = timers.t2_ovf;
            end
            sarc_pkg::TRIG_EXT: begin
                trig = ext_level && !st_reg.ext_prev;
            end
            default: begin
                trig = 1'b0;
            end
        endcase
        in_window = (buf_data >= st_reg.win_lo)
            && (buf_data <= st_reg.win_hi);
        hit = st_reg.ctrl[sarc_pkg::CTRL_WIN_INSIDE] ? in_window
            : !in_window;
        buf_ready = (st_reg.fsm == ST_BUSY);
    end

    // ***********************************
    // Read mux
    // ***********************************
    always_comb begin
        rd_mux = sarc_pkg::RD_ZERO;
        case (bus_req.addr)
            sarc_pkg::ADDR_CTRL: begin
                rd_mux[sarc_pkg::CTRL_BITS-1:0] = st_reg.ctrl;
            end
            sarc_pkg::ADDR_MUX: begin
                rd_mux[sarc_pkg::CW-1:0] = st_reg.mux;
            end
            sarc_pkg::ADDR_STAT: begin
                rd_mux[sarc_pkg::STAT_DONE] = st_reg.done_flag;
                rd_mux[sarc_pkg::STAT_WIN] = st_reg.win_flag;
                rd_mux[sarc_pkg::STAT_BUSY] = (st_reg.fsm == ST_BUSY);
            end
            sarc_pkg::ADDR_RESH: begin
                if (!st_reg.ctrl[sarc_pkg::CTRL_COMPAT8]) begin
                    rd_mux[sarc_pkg::RESH_BITS-1:0] =
                        st_reg.result[RES_W-1:RES_W-sarc_pkg::RESH_BITS];
                end
            end
            sarc_pkg::ADDR_RESL: begin
                if (st_reg.ctrl[sarc_pkg::CTRL_COMPAT8]) begin
                    rd_mux[RES_W-sarc_pkg::COMPAT_SHIFT-1:0] =
                        st_reg.result[RES_W-1:sarc_pkg::COMPAT_SHIFT];
                end else begin
                    rd_mux[RES_W-sarc_pkg::RESH_BITS-1:0] =
                        st_reg.result[RES_W-sarc_pkg::RESH_BITS-1:0];
                end
            end
            sarc_pkg::ADDR_WINH: begin
                rd_mux[RES_W-1:0] = st_reg.win_hi;
            end
            sarc_pkg::ADDR_WINL: begin
                rd_mux[RES_W-1:0] = st_reg.win_lo;
            end
            default: begin
                rd_mux = sarc_pkg::RD_ZERO;
            end
        endcase
    end

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        st_next = st_reg;
        st_next.ext_prev = ext_level;
        st_next.start = 1'b0;
        st_next.rdata = bus_req.rd ? rd_mux : sarc_pkg::RD_ZERO;
        if (bus_req.wr) begin
            case (bus_req.addr)
                sarc_pkg::ADDR_CTRL: begin
                    st_next.ctrl =
                        bus_req.wdata[sarc_pkg::CTRL_BITS-1:0];
                end
                sarc_pkg::ADDR_MUX: begin
                    st_next.mux = bus_req.wdata[sarc_pkg::CW-1:0];
                end
                sarc_pkg::ADDR_STAT: begin
                    if (bus_req.wdata[sarc_pkg::STAT_DONE]) begin
                        st_next.done_flag = 1'b0;
                    end
                    if (bus_req.wdata[sarc_pkg::STAT_WIN]) begin
                        st_next.win_flag = 1'b0;
                    end
                end
                sarc_pkg::ADDR_WINH: begin
                    st_next.win_hi = bus_req.wdata[RES_W-1:0];
                end
                sarc_pkg::ADDR_WINL: begin
                    st_next.win_lo = bus_req.wdata[RES_W-1:0];
                end
                default: begin
                    st_next.mux = st_reg.mux;
                end
            endcase
        end
        case (st_reg.fsm)
            ST_IDLE: begin
                if (trig && enabled) begin
                    st_next.start = 1'b1;
                    st_next.fsm = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (!enabled) begin
                    st_next.fsm = ST_IDLE;
                end else if (buf_valid) begin
                    st_next.result = buf_data;
                    st_next.done_flag = 1'b1;
                    if (hit) begin
                        st_next.win_flag = 1'b1;
                    end
                    st_next.fsm = ST_IDLE;
                end
                // Triggers here fall through unused
            end
            default: begin
                st_next.fsm = ST_IDLE;
            end
        endcase
        st_next.done_irq = st_next.done_flag
            && st_next.ctrl[sarc_pkg::CTRL_DONE_IE];
        st_next.win_irq = st_next.win_flag
            && st_next.ctrl[sarc_pkg::CTRL_WIN_IE];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg.fsm <= ST_IDLE;
            st_reg.ctrl <= sarc_pkg::CTRL_RST;
            st_reg.mux <= sarc_pkg::MUX_RST;
            st_reg.win_hi <= sarc_pkg::WINH_RST;
            st_reg.win_lo <= sarc_pkg::WINL_RST;
            st_reg.result <= sarc_pkg::RES_RST;
            st_reg.done_flag <= 1'b0;
            st_reg.win_flag <= 1'b0;
            st_reg.ext_prev <= 1'b0;
            st_reg.start <= 1'b0;
            st_reg.done_irq <= 1'b0;
            st_reg.win_irq <= 1'b0;
            st_reg.rdata <= sarc_pkg::RD_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign rdata = st_reg.rdata;
    assign done_irq = st_reg.done_irq;
    assign win_irq = st_reg.win_irq;
    assign analog_ctl.power_on = st_reg.ctrl[sarc_pkg::CTRL_EN];
    assign analog_ctl.start = st_reg.start;
    assign analog_ctl.gain_half =
        st_reg.ctrl[sarc_pkg::CTRL_GAIN_HALF];
    assign analog_ctl.mux_sel = st_reg.mux;

endmodule

// *** core/sarc_pkg.sv ***
/*
 * Shared constants and carrier types for the converter control block.
 * Assumes a single 250 MHz clock domain and a plain register port.
 */
package sarc_pkg;

    // ***********************************
    // Widths and timing
    // ***********************************
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int RW = 10;
    localparam int CW = 4;
    localparam real CLK_PERIOD_NS = 4.0;

    // ***********************************
    // Register byte addresses
    // ***********************************
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_MUX = 8'h04;
    localparam logic [AW-1:0] ADDR_START = 8'h08;
    localparam logic [AW-1:0] ADDR_STAT = 8'h0C;
    localparam logic [AW-1:0] ADDR_RESH = 8'h10;
    localparam logic [AW-1:0] ADDR_RESL = 8'h14;
    localparam logic [AW-1:0] ADDR_WINH = 8'h18;
    localparam logic [AW-1:0] ADDR_WINL = 8'h1C;

    // ***********************************
    // Field positions
    // ***********************************
    localparam int CTRL_EN = 0;
    localparam int CTRL_TRIG_LO = 1;
    localparam int CTRL_TRIG_HI = 3;
    localparam int CTRL_GAIN_HALF = 4;
    localparam int CTRL_COMPAT8 = 5;
    localparam int CTRL_DONE_IE = 6;
    localparam int CTRL_WIN_IE = 7;
    localparam int CTRL_WIN_INSIDE = 8;
    localparam int CTRL_BITS = 9;
    localparam int STAT_DONE = 0;
    localparam int STAT_WIN = 1;
    localparam int STAT_BUSY = 2;
    localparam int START_GO = 0;
    localparam int RESH_BITS = 2;
    localparam int COMPAT_SHIFT = 2;

    // ***********************************
    // Reset values and codes
    // ***********************************
    localparam logic [CTRL_BITS-1:0] CTRL_RST = 9'h000;
    localparam logic [CW-1:0] MUX_RST = 4'h0;
    localparam logic [RW-1:0] WINH_RST = 10'h3FF;
    localparam logic [RW-1:0] WINL_RST = 10'h000;
    localparam logic [RW-1:0] RES_RST = 10'h000;
    localparam logic [DW-1:0] RD_ZERO = 16'h0000;
    localparam logic [CW-1:0] MUX_TEMP = 4'h8;
    localparam logic [CW-1:0] MUX_VDD = 4'h9;

    typedef enum logic [2:0] {
        TRIG_SW = 3'h0,
        TRIG_T0 = 3'h1,
        TRIG_T1 = 3'h2,
        TRIG_T2 = 3'h3,
        TRIG_EXT = 3'h4
    } sarc_trig_t;

    // ***********************************
    // Carriers
    // ***********************************
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } sarc_bus_req_t;

    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_ovf;
    } sarc_timers_t;

    typedef struct packed {
        logic power_on;
        logic start;
        logic gain_half;
        logic [CW-1:0] mux_sel;
    } sarc_analog_ctl_t;

endpackage

// *** core/sarc_sync.sv ***
/*
 * Three-stage synchroniser for one pin input.
 * Assumes the input is asynchronous to clk; output follows once
 * the second and third stages agree.
 */
`timescale 1ns/10ps
module sarc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pin side
    input wire logic pin_in,
    // Core side
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sarc_sync_st_t;

    sarc_sync_st_t st_reg;
    sarc_sync_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;

endmodule

// *** core/sarc_buf.sv ***
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes producer holds data while valid and not ready.
 */
`timescale 1ns/10ps
module sarc_buf #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] cnt;
        logic head;
        logic full;
    } sarc_buf_st_t;

    sarc_buf_st_t st_reg;
    sarc_buf_st_t st_next;
    logic push;
    logic pop;

    always_comb begin
        st_next = st_reg;
        pop = out_valid && out_ready;
        push = in_valid && !st_reg.full;
        if (push) begin
            st_next.mem[st_reg.head ^ st_reg.cnt[0]] = in_data;
        end
        if (pop) begin
            st_next.head = !st_reg.head;
        end
        st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
        st_next.full = st_next.cnt[1];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready = !st_reg.full;
    assign out_valid = (st_reg.cnt != 2'h0);
    assign out_data = st_reg.mem[st_reg.head];

endmodule

// *** sim/sarc_ctrl_properties.sv ***
/* Port assertions for the converter control block.
   Assumes a bind into sarc_ctrl and one clock domain. */
`timescale 1ns/10ps
module sarc_ctrl_properties #(
    parameter int RES_W = 10
) (
    // Watched ports
    input wire logic clk,
    input wire logic rstn,
    input wire sarc_pkg::sarc_bus_req_t bus_req,
    input wire logic [sarc_pkg::DW-1:0] rdata,
    input wire sarc_pkg::sarc_timers_t timers,
    input wire logic ext_start_pin,
    input wire sarc_pkg::sarc_analog_ctl_t analog_ctl,
    input wire logic conv_valid,
    input wire logic [RES_W-1:0] conv_data,
    input wire logic conv_ready,
    input wire logic done_irq,
    input wire logic win_irq
);
    logic [8:0] ctl_q;
    logic pend, hs, trig;
    assign hs = conv_valid && conv_ready;
    always_comb begin
        case (ctl_q[3:1])
            3'h0: trig = bus_req.wr && bus_req.wdata[0]
                && bus_req.addr == sarc_pkg::ADDR_START;
            3'h1: trig = timers.t0_ovf;
            3'h2: trig = timers.t1_ovf;
            3'h3: trig = timers.t2_ovf;
            default: trig = 1'h0;
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= sarc_pkg::CTRL_RST;
            pend <= 1'h0;
        end else begin
            if (bus_req.wr && bus_req.addr == sarc_pkg::ADDR_CTRL) begin
                ctl_q <= bus_req.wdata[8:0];
            end
            if (analog_ctl.start) begin
                pend <= 1'h1;
            end else if (hs || !ctl_q[0]) begin
                pend <= 1'h0;
            end
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_start_pulse: assert property (
        analog_ctl.start |=> !analog_ctl.start)
        else $error("start pulse too long");
    chk_trig_start: assert property (
        trig && ctl_q[0] && !pend && !analog_ctl.start && !$past(hs)
        && !$past(hs, 2) && !$past(hs, 3) |=> analog_ctl.start)
        else $error("trigger gave no start");
    chk_start_cause: assert property (
        analog_ctl.start |-> $past(trig) || ctl_q[3:1] == 3'h4)
        else $error("start without trigger");
    chk_no_retrig: assert property (
        analog_ctl.start |-> !pend)
        else $error("start while busy");
    chk_start_power: assert property (
        analog_ctl.start |-> analog_ctl.power_on)
        else $error("start while shut down");
    chk_ctl_levels: assert property (
        analog_ctl.power_on == ctl_q[0] && analog_ctl.gain_half == ctl_q[4])
        else $error("power or gain wrong");
    chk_mux_follow: assert property (
        $past(bus_req.wr) && $past(bus_req.addr) == sarc_pkg::ADDR_MUX
        |-> analog_ctl.mux_sel == $past(bus_req.wdata[3:0]))
        else $error("mux select stale");
    chk_done_mask: assert property (
        done_irq |-> ctl_q[6])
        else $error("done request masked");
    chk_win_mask: assert property (
        win_irq |-> ctl_q[7])
        else $error("window request masked");
    cov_start: cover property (analog_ctl.start);
    cov_done: cover property ($rose(done_irq));
    cov_win: cover property ($rose(win_irq));
endmodule
bind sarc_ctrl sarc_ctrl_properties #(.RES_W(RES_W)) sarc_ctrl_properties_inst (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .timers(timers), .ext_start_pin(ext_start_pin),
    .analog_ctl(analog_ctl), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready),
    .done_irq(done_irq), .win_irq(win_irq)
);

// *** sim/sarc_analog_model.sv ***
/* Behavioural analog converter core.
   Assumes one start pulse per word; lat of at least 1. */
`timescale 1ns/10ps
module sarc_analog_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control and stimulus
    input wire sarc_pkg::sarc_analog_ctl_t ctl,
    input wire logic [9:0] level,
    input wire logic [7:0] lat,
    // Result channel
    output logic conv_valid,
    output logic [9:0] conv_data,
    input wire logic conv_ready
);
    logic [7:0] cnt;
    logic [9:0] word;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h00;
            conv_valid <= 1'h0;
            conv_data <= 10'h2AA;
        end else if (conv_valid) begin
            if (conv_ready) begin
                conv_valid <= 1'h0;
                conv_data <= ~conv_data;
            end
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            conv_data <= (cnt == 8'h01) ? word : ~conv_data;
            conv_valid <= (cnt == 8'h01);
        end else if (ctl.start && ctl.power_on) begin
            word <= ctl.gain_half ? {1'h0, level[9:1]} : level;
            cnt <= lat;
        end
    end
endmodule

// *** sim/sarc_ctrl_bench.sv ***
/* Self-checking bench for the converter control block.
   Assumes the analog model on the result channel. */
`timescale 1ns/10ps
module sarc_ctrl_bench;
    logic clk, rstn, ext, cv, cr, done_irq, win_irq;
    sarc_pkg::sarc_bus_req_t req;
    sarc_pkg::sarc_timers_t tmr;
    sarc_pkg::sarc_analog_ctl_t actl;
    logic [15:0] rdata;
    logic [9:0] cd, level;
    logic [7:0] lat;
    int errors, n_compared, starts;
    sarc_ctrl sarc_ctrl_inst (.clk(clk), .rstn(rstn), .bus_req(req),
        .rdata(rdata), .timers(tmr), .ext_start_pin(ext),
        .analog_ctl(actl), .conv_valid(cv), .conv_data(cd),
        .conv_ready(cr), .done_irq(done_irq), .win_irq(win_irq));
    sarc_analog_model sarc_analog_model_inst (.clk(clk), .rstn(rstn),
        .ctl(actl), .level(level), .lat(lat), .conv_valid(cv),
        .conv_data(cd), .conv_ready(cr));
    always @(posedge clk) if (actl.start === 1'h1) starts++;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        req <= '{a, d, 1'h1, 1'h0};
        @(posedge clk);
        req.wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rc(string n, logic [7:0] a, logic [15:0] e);
        req <= '{a, 16'h0000, 1'h0, 1'h1};
        @(posedge clk);
        req.rd <= 1'h0;
        @(negedge clk);
        chk(n, e, rdata);
        @(posedge clk);
    endtask
    task automatic fire(int s);
        if (s == 0) wr(sarc_pkg::ADDR_START, 16'h0001);
        else if (s == 4) begin
            ext <= 1'h1;
            repeat (6) @(posedge clk);
            ext <= 1'h0;
        end else tmr <= sarc_pkg::sarc_timers_t'(3'h4 >> (s - 1));
        @(posedge clk);
        tmr <= 3'h0;
        @(posedge clk);
    endtask
    task automatic poll();
        logic d;
        d = 1'h0;
        for (int i = 0; i < 60 && d !== 1'h1; i++) begin
            req <= '{sarc_pkg::ADDR_STAT, 16'h0000, 1'h0, 1'h1};
            @(posedge clk);
            req.rd <= 1'h0;
            @(negedge clk);
            d = rdata[sarc_pkg::STAT_DONE];
            @(posedge clk);
        end
        chk("poll", 16'h0001, 16'(d));
    endtask
    task automatic run(logic [15:0] c, int s, logic [9:0] v);
        level <= v;
        wr(sarc_pkg::ADDR_CTRL, c);
        fire(s);
        poll();
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        rc("winh", sarc_pkg::ADDR_WINH, 16'h03FF);
        rc("stat", sarc_pkg::ADDR_STAT, 16'h0000);
        rc("hole", 8'h20, 16'h0000);
    endtask
    task automatic t_trig();
        logic [9:0] v;
        for (int s = 0; s < 5; s++) begin
            v = 10'h2C5 ^ 10'(s * 211);
            run(16'h0041 | 16'(s << 1), s, v);
            rc("stat", sarc_pkg::ADDR_STAT, 16'h0001);
            chk("done_irq", 16'h0001, 16'(done_irq));
            rc("resh", sarc_pkg::ADDR_RESH, 16'(v[9:8]));
            rc("resl", sarc_pkg::ADDR_RESL, 16'(v[7:0]));
            wr(sarc_pkg::ADDR_STAT, 16'h0001);
            rc("clr", sarc_pkg::ADDR_STAT, 16'h0000);
        end
    endtask
    task automatic t_format();
        wr(sarc_pkg::ADDR_MUX, 16'(sarc_pkg::MUX_TEMP));
        chk("mux", 16'(sarc_pkg::MUX_TEMP), 16'(actl.mux_sel));
        wr(sarc_pkg::ADDR_MUX, 16'(sarc_pkg::MUX_VDD));
        chk("mux", 16'(sarc_pkg::MUX_VDD), 16'(actl.mux_sel));
        run(16'h0031, 0, 10'h3B7);
        chk("gain", 16'h0001, 16'(actl.gain_half));
        rc("resl8", sarc_pkg::ADDR_RESL, 16'h0076);
        rc("resh8", sarc_pkg::ADDR_RESH, 16'h0000);
        wr(sarc_pkg::ADDR_STAT, 16'h0001);
    endtask
    task automatic t_window();
        logic [15:0] c [3] = '{16'h0181, 16'h0181, 16'h0081};
        logic [9:0] v [3] = '{10'h100, 10'h201, 10'h0FF};
        wr(sarc_pkg::ADDR_WINL, 16'h0100);
        wr(sarc_pkg::ADDR_WINH, 16'h0200);
        for (int k = 0; k < 3; k++) begin
            run(c[k], 0, v[k]);
            chk("win_irq", 16'(k != 1), 16'(win_irq));
            chk("done_irq", 16'h0000, 16'(done_irq));
            rc("wstat", sarc_pkg::ADDR_STAT, 16'((k != 1) * 2 + 1));
            wr(sarc_pkg::ADDR_STAT, 16'h0003);
        end
    endtask
    task automatic t_busy();
        lat <= 8'h1E;
        starts = 0;
        level <= 10'h0AA;
        wr(sarc_pkg::ADDR_CTRL, 16'h0003);
        fire(1);
        fire(1);
        poll();
        chk("starts", 16'h0001, 16'(starts));
        rc("resl", sarc_pkg::ADDR_RESL, 16'h00AA);
        wr(sarc_pkg::ADDR_STAT, 16'h0001);
        lat <= 8'h02;
    endtask
    task automatic t_off();
        starts = 0;
        wr(sarc_pkg::ADDR_CTRL, 16'h0000);
        fire(0);
        chk("starts", 16'h0000, 16'(starts));
        chk("power", 16'h0000, 16'(actl.power_on));
        chk("ready", 16'h0001, 16'(cr));
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        errors++;
        conclude();
    end
    initial begin
        {rstn, ext, tmr, req, level} = '0;
        lat = 8'h02;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        t_regs();
        t_trig();
        t_format();
        t_window();
        t_busy();
        t_off();
        conclude();
    end
endmodule
